// *** rtl/wpl_defines.svh ***
`ifndef WPL_DEFINES_SVH
`define WPL_DEFINES_SVH
// Clock rate in Hz
`define WPL_CLK_HZ 50000000
// Times in whole microseconds
`define WPL_IGN_FILT_MIN_US 7500
`define WPL_IGN_FILT_CYC ((`WPL_IGN_FILT_MIN_US * (`WPL_CLK_HZ / 1000000)))
`define WPL_CAN_FILT_MIN_US 350
`define WPL_CAN_FILT_CYC ((`WPL_CAN_FILT_MIN_US * (`WPL_CLK_HZ / 1000000)))
`define WPL_SOFT_START_MIN_US 1000
`define WPL_SOFT_START_CYC ((`WPL_SOFT_START_MIN_US * (`WPL_CLK_HZ / 1000000)))
`define WPL_RST_EXT_SHORT_US 1400
`define WPL_RST_EXT_SHORT_CYC ((`WPL_RST_EXT_SHORT_US * (`WPL_CLK_HZ / 1000000)))
`define WPL_RST_EXT_LONG_US 4500
`define WPL_RST_EXT_LONG_CYC ((`WPL_RST_EXT_LONG_US * (`WPL_CLK_HZ / 1000000)))
// Field positions and counter width
`define WPL_SENS_EN_BIT 0
`define WPL_SAF1_OT_BIT 2
`define WPL_CFG_PWRL_BIT 4
`define WPL_STAT_IGN_BIT 0
`define WPL_CNT_W 20
`endif

// *** rtl/wpl_pkg.sv ***
package wpl_pkg;
  typedef enum logic [4:0] {
    WPL_STANDBY = 5'b00001,
    WPL_RAMP = 5'b00010,
    WPL_RESET = 5'b00100,
    WPL_DIAG = 5'b01000,
    WPL_ACTIVE = 5'b10000
  } wpl_state_t;

  typedef struct packed {
    logic ignFilt;
    logic canLatched;
    logic powerLatch;
    logic trackMode;
    logic sensEnable;
    logic sensOverTemp;
  } wpl_status_t;
endpackage : wpl_pkg

// *** rtl/wpl_wakeup_power_latch.sv ***
`timescale 1ns/1ns
`include "wpl_defines.svh"
// What this block does
// - Tracking reference above 1.2 V selects tracking mode, grounded selects non-tracking.
// - Sensor mode sampled at first rail ramp-up, then held latched.
// - Sensor supply starts off; MCU enables via control bit 0 after reset release.
// - Enable starts 1-2 ms soft-start; feedback ramps only afterwards.
// - Sensor over-temperature clears only the sensor enable bit.
// - Re-enable needs status bit 2 cleared by read before setting enable.
// - Ignition wake is level-sensitive with 7.5-22 ms deglitch.
// - MCU sets power latch bit 4; device reports filtered ignition at bit 0.
// - Clearing power latch enters standby once neither ignition nor the CAN wake latch holds.
// - Safety config writes, power latch included, accepted only in diagnostic state.
// - A CAN wake event clears the power latch bit.
// - Optional reset-state entry on ignition wake during after-run hold phase.
// - CAN wake is level-sensitive with at least 350 us deglitch.
// - Filtered CAN wake is latched; standby command ends it.
// - Reset to MCU released after extension delay once io and core rails good.
// - Extension 1.4 ms with pin grounded, 4.5 ms with resistor.
module wpl_wakeup_power_latch
  import wpl_pkg::*;
#(
  parameter int IGN_FILT_CYC = `WPL_IGN_FILT_CYC,
  parameter int CAN_FILT_CYC = `WPL_CAN_FILT_CYC,
  parameter int SOFT_START_CYC = `WPL_SOFT_START_CYC,
  parameter int RST_EXT_SHORT_CYC = `WPL_RST_EXT_SHORT_CYC,
  parameter int RST_EXT_LONG_CYC = `WPL_RST_EXT_LONG_CYC
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ignitionWakeInput,
  input wire logic canWakeInput,
  input wire logic trackAboveThreshold,
  input wire logic ioSupplyRailGood,
  input wire logic coreSupplyRailGood,
  input wire logic resetDelayResistorPin,
  input wire logic sensorOverTemp,
  input wire logic diagRequest,
  input wire logic activeRequest,
  input wire logic postRunResetEnable,
  input wire logic sensEnableWrite,
  input wire logic sensEnableData,
  input wire logic safetyCfgWrite,
  input wire logic [7:0] safetyCfgData,
  input wire logic safetyStat1Read,
  input wire logic canWakeStandbyCommand,
  output logic powerOn,
  output logic mcuResetOutput_n,
  output logic sensorSupplyOutputEnable,
  output logic sensorFeedbackRampEnable,
  output logic [7:0] sensorSupplyControlReg,
  output logic [7:0] safetyFunctionConfigReg,
  output logic [7:0] safetyStat1Reg,
  output logic [7:0] deviceStatusReg,
  output wpl_status_t status,
  output wpl_state_t state
);

  wpl_state_t state_ff, nxt_state;
  logic [`WPL_CNT_W-1:0] ignCnt_ff, canCnt_ff, extCnt_ff, ssCnt_ff;
  logic ignFilt_ff, canFilt_ff, canLatch_ff, pwrLatch_ff;
  logic modeLatched_ff, trackMode_ff, sensEn_ff, otFlag_ff, ssDone_ff;
  logic mcuResetN_ff, powerOn_ff, ignFiltPrev_ff, canFiltPrev_ff;
  logic longExt_ff;

  // Deglitch: a level change must persist for the full filter time
  wire ignDiffers = ignitionWakeInput != ignFilt_ff;
  wire canDiffers = canWakeInput != canFilt_ff;
  wire ignFiltDone = ignDiffers && (ignCnt_ff == `WPL_CNT_W'(IGN_FILT_CYC - 1));
  wire canFiltDone = canDiffers && (canCnt_ff == `WPL_CNT_W'(CAN_FILT_CYC - 1));
  wire canWakeEvent = canFilt_ff && !canFiltPrev_ff;
  wire ignWakeEvent = ignFilt_ff && !ignFiltPrev_ff;
  wire railsGood = ioSupplyRailGood && coreSupplyRailGood;
  wire [`WPL_CNT_W-1:0] extTarget = longExt_ff ? `WPL_CNT_W'(RST_EXT_LONG_CYC - 1)
                                               : `WPL_CNT_W'(RST_EXT_SHORT_CYC - 1);
  wire extDone = extCnt_ff == extTarget;
  wire holdAwake = ignFilt_ff || pwrLatch_ff || canLatch_ff;
  wire inDiag = state_ff == WPL_DIAG;
  wire cfgAccepted = safetyCfgWrite && inDiag;
  wire sensSetReq = sensEnableWrite && sensEnableData && mcuResetN_ff && !otFlag_ff;
  wire postRunIgn = ignWakeEvent && pwrLatch_ff && postRunResetEnable;
  wire inRunState = (state_ff == WPL_DIAG) || (state_ff == WPL_ACTIVE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      WPL_STANDBY:
        if (holdAwake)
          nxt_state = WPL_RAMP;
      WPL_RAMP:
        if (!holdAwake)
          nxt_state = WPL_STANDBY;
        else if (railsGood)
          nxt_state = WPL_RESET;
      WPL_RESET:
        if (!holdAwake)
          nxt_state = WPL_STANDBY;
        else if (!railsGood)
          nxt_state = WPL_RAMP;
        else if (extDone)
          nxt_state = WPL_DIAG;
      WPL_DIAG:
        if (!holdAwake)
          nxt_state = WPL_STANDBY;
        else if (postRunIgn || !railsGood)
          nxt_state = WPL_RESET;
        else if (activeRequest)
          nxt_state = WPL_ACTIVE;
      WPL_ACTIVE:
        if (!holdAwake)
          nxt_state = WPL_STANDBY;
        else if (postRunIgn || !railsGood)
          nxt_state = WPL_RESET;
        else if (diagRequest)
          nxt_state = WPL_DIAG;
      default:
        nxt_state = WPL_STANDBY;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_ff <= WPL_STANDBY;
      ignCnt_ff <= '0;
      canCnt_ff <= '0;
      ignFilt_ff <= 1'b0;
      canFilt_ff <= 1'b0;
      ignFiltPrev_ff <= 1'b0;
      canFiltPrev_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ignFiltPrev_ff <= ignFilt_ff;
      canFiltPrev_ff <= canFilt_ff;
      ignCnt_ff <= (ignDiffers && !ignFiltDone) ? ignCnt_ff + 1'b1 : '0;
      canCnt_ff <= (canDiffers && !canFiltDone) ? canCnt_ff + 1'b1 : '0;
      if (ignFiltDone)
        ignFilt_ff <= ignitionWakeInput;
      if (canFiltDone)
        canFilt_ff <= canWakeInput;
    end
  end

  // CAN latch: a new wake beats a standby command arriving in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      canLatch_ff <= 1'b0;
      pwrLatch_ff <= 1'b0;
    end
    else
    begin
      if (canWakeEvent)
        canLatch_ff <= 1'b1;
      else if (canWakeStandbyCommand)
        canLatch_ff <= 1'b0;
      if (canWakeEvent)
        pwrLatch_ff <= 1'b0;
      else if (cfgAccepted)
        pwrLatch_ff <= safetyCfgData[`WPL_CFG_PWRL_BIT];
    end
  end

  // Mode sampled while the first ramp runs; frozen once rails are up the first time
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      modeLatched_ff <= 1'b0;
      trackMode_ff <= 1'b0;
      longExt_ff <= 1'b0;
    end
    else if (!modeLatched_ff && state_ff == WPL_RAMP)
    begin
      trackMode_ff <= trackAboveThreshold;
      longExt_ff <= resetDelayResistorPin;
      modeLatched_ff <= railsGood;
    end
  end

  // Reset extension counts only while both rails stay good
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      extCnt_ff <= '0;
      mcuResetN_ff <= 1'b0;
      powerOn_ff <= 1'b0;
    end
    else
    begin
      extCnt_ff <= (state_ff == WPL_RESET && railsGood && !extDone) ? extCnt_ff + 1'b1 : '0;
      mcuResetN_ff <= (nxt_state == WPL_DIAG) || (nxt_state == WPL_ACTIVE);
      powerOn_ff <= nxt_state != WPL_STANDBY;
    end
  end

  // Over-temperature wins over a same-cycle enable write, and over the read clear only while the supply is on
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sensEn_ff <= 1'b0;
      otFlag_ff <= 1'b0;
      ssCnt_ff <= '0;
      ssDone_ff <= 1'b0;
    end
    else
    begin
      if (sensorOverTemp || !inRunState)
        sensEn_ff <= 1'b0;
      else if (sensEnableWrite)
        sensEn_ff <= sensSetReq;
      if (sensorOverTemp && sensEn_ff)
        otFlag_ff <= 1'b1;
      else if (safetyStat1Read)
        otFlag_ff <= 1'b0;
      if (!sensEn_ff)
      begin
        ssCnt_ff <= '0;
        ssDone_ff <= 1'b0;
      end
      else if (ssCnt_ff == `WPL_CNT_W'(SOFT_START_CYC - 1))
        ssDone_ff <= 1'b1;
      else
        ssCnt_ff <= ssCnt_ff + 1'b1;
    end
  end

  always_comb
  begin
    state = state_ff;
    powerOn = powerOn_ff;
    mcuResetOutput_n = mcuResetN_ff;
    sensorSupplyOutputEnable = sensEn_ff;
    sensorFeedbackRampEnable = ssDone_ff;
    sensorSupplyControlReg = {7'h00, sensEn_ff};
    safetyFunctionConfigReg = {3'h0, pwrLatch_ff, 4'h0};
    safetyStat1Reg = {5'h00, otFlag_ff, 2'h0};
    deviceStatusReg = {7'h00, ignFilt_ff};
    status = '{ignFilt: ignFilt_ff, canLatched: canLatch_ff, powerLatch: pwrLatch_ff,
               trackMode: trackMode_ff, sensEnable: sensEn_ff, sensOverTemp: otFlag_ff};
  end

  a_reset_held_low: assert property (@(posedge mclk) disable iff (!resetn)
    (state_ff == WPL_RESET) |=> !mcuResetN_ff || state_ff != WPL_RESET)
    else $error("Reset released while still in reset state");
  a_cfg_diag_only: assert property (@(posedge mclk) disable iff (!resetn)
    (safetyCfgWrite && !inDiag && !canWakeEvent) |=> pwrLatch_ff == $past(pwrLatch_ff))
    else $error("Config write took effect outside diagnostic state");
  a_can_clears_latch: assert property (@(posedge mclk) disable iff (!resetn)
    canWakeEvent |=> !pwrLatch_ff && canLatch_ff)
    else $error("CAN wake did not clear power latch");
  a_ot_disables: assert property (@(posedge mclk) disable iff (!resetn)
    (sensorOverTemp && sensEn_ff) |=> !sensEn_ff && otFlag_ff)
    else $error("Over-temperature did not switch sensor supply off");
  a_reenable_blocked: assert property (@(posedge mclk) disable iff (!resetn)
    (otFlag_ff && !safetyStat1Read) |=> !sensEn_ff)
    else $error("Sensor supply re-enabled before status read");
  a_ramp_after_ss: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(sensEn_ff) |-> !ssDone_ff [*2])
    else $error("Feedback ramp started without soft-start");
  a_standby_when_free: assert property (@(posedge mclk) disable iff (!resetn)
    (!holdAwake && state_ff != WPL_STANDBY) |=> state_ff == WPL_STANDBY)
    else $error("Standby not entered when nothing holds device awake");
  a_mode_frozen: assert property (@(posedge mclk) disable iff (!resetn)
    $past(modeLatched_ff) |-> $stable(trackMode_ff))
    else $error("Sensor mode changed after latching");
  a_sens_off_reset: assert property (@(posedge mclk) disable iff (!resetn)
    !mcuResetN_ff |=> !sensEn_ff || $past(mcuResetN_ff))
    else $error("Sensor supply enabled while MCU held in reset");
  a_ign_filter: assert property (@(posedge mclk) disable iff (!resetn)
    ($past(resetn) && $changed(ignFilt_ff)) |-> $past(ignCnt_ff) == `WPL_CNT_W'(IGN_FILT_CYC - 1))
    else $error("Ignition level accepted before full deglitch time");
  a_can_filter: assert property (@(posedge mclk) disable iff (!resetn)
    ($past(resetn) && $changed(canFilt_ff)) |-> $past(canCnt_ff) == `WPL_CNT_W'(CAN_FILT_CYC - 1))
    else $error("CAN wake level accepted before full deglitch time");
  a_ext_count: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(mcuResetN_ff) |-> $past(extCnt_ff) == (longExt_ff ? `WPL_CNT_W'(RST_EXT_LONG_CYC - 1)
                                                             : `WPL_CNT_W'(RST_EXT_SHORT_CYC - 1)))
    else $error("Reset released after wrong extension time");
  a_ss_length: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(ssDone_ff) |-> $past(ssCnt_ff) == `WPL_CNT_W'(SOFT_START_CYC - 1))
    else $error("Soft-start ended after wrong time");
  a_sens_outside_run: assert property (@(posedge mclk) disable iff (!resetn)
    !inRunState |=> !sensEn_ff)
    else $error("Sensor supply on outside run states");
  a_postrun_reset: assert property (@(posedge mclk) disable iff (!resetn)
    (postRunIgn && inRunState && holdAwake) |=> state_ff == WPL_RESET && !mcuResetN_ff)
    else $error("Ignition wake in after-run phase did not reset MCU");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (canLatch_ff && !canWakeStandbyCommand) |=> canLatch_ff)
    else $error("CAN wake latch lost without standby command");
  a_wake_leaves_standby: assert property (@(posedge mclk) disable iff (!resetn)
    (state_ff == WPL_STANDBY && holdAwake) |=> state_ff == WPL_RAMP && powerOn_ff)
    else $error("Wake source did not start power-up");

endmodule : wpl_wakeup_power_latch

// *** verif/wpl_mcu_model.sv ***
`timescale 1ns/1ns
module wpl_mcu_model
(
  input wire logic mclk,
  output logic sensEnableWrite,
  output logic sensEnableData,
  output logic safetyCfgWrite,
  output logic [7:0] safetyCfgData,
  output logic safetyStat1Read,
  output logic canWakeStandbyCommand
);
  initial
  begin
    {sensEnableWrite, sensEnableData, safetyCfgWrite, safetyStat1Read, canWakeStandbyCommand} = 5'h00;
    safetyCfgData = 8'h00;
  end

  // One strobe for one cycle; data is scrambled after release so stale values are never trusted
  task automatic op(input int k, input logic [7:0] d);
    @(posedge mclk);
    sensEnableData <= d[0];
    safetyCfgData <= d;
    sensEnableWrite <= (k == 0);
    safetyCfgWrite <= (k == 1);
    safetyStat1Read <= (k == 2);
    canWakeStandbyCommand <= (k == 3);
    @(posedge mclk);
    {sensEnableWrite, safetyCfgWrite, safetyStat1Read, canWakeStandbyCommand} <= 4'h0;
    sensEnableData <= ~d[0];
    safetyCfgData <= ~d;
  endtask : op
endmodule : wpl_mcu_model

// *** verif/wpl_wakeup_power_latch_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define WAITF(c, lim, nm) begin for (int i = 0; i < lim && !(c); i++) step(); \
  if (!(c)) begin n_errors++; $display("unexpected %s exp 1 got 0", nm); stop_test(); end end
module wpl_wakeup_power_latch_tb;
  import wpl_pkg::*;
  logic mclk = 0, resetn = 0, ignition_wake_input = 0, can = 0, track = 1, ioGood = 0, coreGood = 0;
  logic resPin = 0, ot = 0, diagReq = 0, actReq = 0, prEn = 0;
  logic sEw, sEd, cW, s1R, cSt, powerOn, rstN, sensOut, ramp;
  logic [7:0] cfgD, sensCtrl, cfgReg, stat1, devStat;
  wpl_status_t status;
  wpl_state_t state;
  int n_errors = 0, n_tests = 0;

  wpl_wakeup_power_latch #(.IGN_FILT_CYC(20), .CAN_FILT_CYC(10), .SOFT_START_CYC(16),
    .RST_EXT_SHORT_CYC(12), .RST_EXT_LONG_CYC(30)) wpl_wakeup_power_latch_i (
    .mclk(mclk), .resetn(resetn), .ignitionWakeInput(ignition_wake_input), .canWakeInput(can),
    .trackAboveThreshold(track), .ioSupplyRailGood(ioGood), .coreSupplyRailGood(coreGood),
    .resetDelayResistorPin(resPin), .sensorOverTemp(ot), .diagRequest(diagReq),
    .activeRequest(actReq), .postRunResetEnable(prEn), .sensEnableWrite(sEw),
    .sensEnableData(sEd), .safetyCfgWrite(cW), .safetyCfgData(cfgD), .safetyStat1Read(s1R),
    .canWakeStandbyCommand(cSt), .powerOn(powerOn), .mcuResetOutput_n(rstN),
    .sensorSupplyOutputEnable(sensOut), .sensorFeedbackRampEnable(ramp),
    .sensorSupplyControlReg(sensCtrl), .safetyFunctionConfigReg(cfgReg),
    .safetyStat1Reg(stat1), .deviceStatusReg(devStat), .status(status), .state(state));

  wpl_mcu_model wpl_mcu_model_i (.mclk(mclk), .sensEnableWrite(sEw), .sensEnableData(sEd),
    .safetyCfgWrite(cW), .safetyCfgData(cfgD), .safetyStat1Read(s1R), .canWakeStandbyCommand(cSt));

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic t_powerup;
    {ignition_wake_input, ioGood, coreGood} <= 3'h7;
    step(10);
    `CHK("early wake", 1'b0, powerOn)
    `WAITF(powerOn === 1'b1, 30, "wake")
    `CHK("ign status", 1'b1, devStat[0])
    `CHK("sensor off", 1'b0, sensOut)
    `WAITF(state === WPL_RESET, 10, "reset state")
    track <= 1'b0;
    step(11);
    `CHK("reset held", 1'b0, rstN)
    `WAITF(rstN === 1'b1, 5, "reset release")
    `CHK("diag", WPL_DIAG, state)
    `CHK("mode latched", 1'b1, status.trackMode)
    $display("powerup done");
  endtask : t_powerup

  task automatic t_sensor;
    wpl_mcu_model_i.op(0, 8'h01);
    #1 `CHK("sens on", 1'b1, sensOut)
    step(10);
    `CHK("ramp early", 1'b0, ramp)
    `WAITF(ramp === 1'b1, 12, "ramp")
    ot <= 1'b1;
    step();
    ot <= 1'b0;
    step();
    `CHK("ot off", 1'b0, sensOut)
    `CHK("ot flag", 1'b1, stat1[2])
    `CHK("others on", 1'b1, powerOn)
    wpl_mcu_model_i.op(0, 8'h01);
    #1 `CHK("no reenable", 1'b0, sensOut)
    wpl_mcu_model_i.op(2, 8'h00);
    #1 `CHK("ot cleared", 1'b0, stat1[2])
    wpl_mcu_model_i.op(0, 8'h01);
    #1 `CHK("reenable", 1'b1, sensOut)
    $display("sensor done");
  endtask : t_sensor

  task automatic t_latch;
    wpl_mcu_model_i.op(1, 8'h10);
    #1 `CHK("latch set", 1'b1, cfgReg[4])
    ignition_wake_input <= 1'b0;
    step(25);
    `CHK("ign low", 1'b0, devStat[0])
    `CHK("held on", 1'b1, powerOn)
    prEn <= 1'b1;
    ignition_wake_input <= 1'b1;
    `WAITF(state === WPL_RESET, 30, "after_run_hold_phase reset")
    `CHK("after_run_hold_phase mcu_reset_output_n", 1'b0, rstN)
    `WAITF(rstN === 1'b1, 40, "rerelease")
    ignition_wake_input <= 1'b0;
    can <= 1'b1;
    step(5);
    can <= 1'b0;
    step(25);
    `CHK("can glitch", 1'b0, status.canLatched)
    can <= 1'b1;
    step(15);
    can <= 1'b0;
    step();
    `CHK("can latched", 1'b1, status.canLatched)
    `CHK("latch cleared", 1'b0, cfgReg[4])
    `CHK("can holds", 1'b1, powerOn)
    actReq <= 1'b1;
    step();
    actReq <= 1'b0;
    wpl_mcu_model_i.op(1, 8'h10);
    #1 `CHK("cfg refused", 1'b0, cfgReg[4])
    wpl_mcu_model_i.op(3, 8'h00);
    #1 `WAITF(state === WPL_STANDBY, 5, "standby")
    `CHK("power off", 1'b0, powerOn)
    $display("latch done");
  endtask : t_latch

  // Second power-up after a mid-run reset: resistor fitted, reference grounded
  task automatic t_repower;
    resetn <= 1'b0;
    {resPin, track, ignition_wake_input} <= 3'h4;
    step(3);
    resetn <= 1'b1;
    step();
    `CHK("rst after reset", 1'b0, rstN)
    `CHK("off after reset", 1'b0, powerOn)
    ignition_wake_input <= 1'b1;
    `WAITF(state === WPL_RESET, 40, "second ramp")
    track <= 1'b1;
    resPin <= 1'b0;
    step(29);
    `CHK("long ext held", 1'b0, rstN)
    `WAITF(rstN === 1'b1, 3, "long release")
    `CHK("mode nontrack", 1'b0, status.trackMode)
    wpl_mcu_model_i.op(0, 8'h01);
    #1 `CHK("ctrl bit set", 1'b1, sensCtrl[0])
    wpl_mcu_model_i.op(0, 8'h00);
    #1 `CHK("ctrl bit clear", 1'b0, sensCtrl[0])
    coreGood <= 1'b0;
    step(2);
    `CHK("rail loss reset", 1'b0, rstN)
    coreGood <= 1'b1;
    `WAITF(rstN === 1'b1, 40, "rail return")
    `CHK("mode held", 1'b0, status.trackMode)
    actReq <= 1'b1;
    step();
    `CHK("active", WPL_ACTIVE, state)
    {actReq, diagReq} <= 2'h1;
    step();
    diagReq <= 1'b0;
    `CHK("back to diag", WPL_DIAG, state)
    wpl_mcu_model_i.op(1, 8'h10);
    #1 ignition_wake_input <= 1'b0;
    step(22);
    `CHK("ign dropped", 1'b0, status.ignFilt)
    `CHK("latch keeps on", 1'b1, powerOn)
    wpl_mcu_model_i.op(1, 8'h00);
    #1 `WAITF(state === WPL_STANDBY, 3, "latch release")
    `CHK("reset on standby", 1'b0, rstN)
    $display("repower done");
  endtask : t_repower

  initial
  begin
    step(3);
    resetn <= 1'b1;
    step();
    t_powerup();
    t_sensor();
    t_latch();
    t_repower();
    stop_test();
  end
endmodule : wpl_wakeup_power_latch_tb
